//--- hdl/tspc_cmp.sv
`timescale 1ns/1ps
`default_nettype none

module tspc_cmp (
   input wire tspc_pkg::tspc_tod_t now_tod,
   input wire tspc_pkg::tspc_tod_t set_tod,
   output logic reached
);
   import tspc_pkg::*;

   // ==========================================================
   // Time of day at or past setpoint
   // Goes low again at 0:00:00 since the time of day wraps
   always_comb begin
      reached = ({now_tod.hour, now_tod.minute, now_tod.second} >=
                 {set_tod.hour, set_tod.minute, set_tod.second});
   end

endmodule

`default_nettype wire

//--- hdl/tspc_top.sv
// Contract
// - Seven command outputs in fixed index order
// - Daily timers on from setpoint to midnight
// - Timer hours 0-23, reset 8 and 17
// - Timer minute, second 0-59, reset zero
// - Day match whole day, 1-31, reset 1
// - Hour match whole hour, 0-23, reset 12
// - Minute match whole minute, 0-59, reset 0
// - Second match during second, 0-59, reset 0
// - Weekday match whole day of enabled weekday
// - Seven weekday enables, Monday-Friday on at reset
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tspc_defs.svh"

module tspc_top #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tspc_pkg::tspc_cal_t now_time,
   input wire logic sec_tick,
   output tspc_pkg::tspc_cmd_t cmd_out
);
   import tspc_pkg::*;

   // ==========================================================
   // Configuration state
   tspc_tod_t timer1;
   tspc_tod_t timer2;
   tspc_tod_t act_tod;
   logic [4:0] act_day;
   logic [6:0] weekday_en;
   logic ctrl_en;
   tspc_cal_t now_seen;
   tspc_cmd_t cmd;

   // ==========================================================
   // Bus decode
   logic setup_phase;
   logic access_phase;
   logic wr_access;
   logic [7:0] offset;
   logic addr_hit;
   logic addr_ro;
   logic data_ok;
   logic wr_take;
   tspc_tod_t wr_tod;
   logic [4:0] wr_day;
   logic [31:0] next_prdata;

   function automatic tspc_tod_t tod_of(input logic [31:0] w);
      tspc_tod_t t;
      t.hour = w[`TSPC_HOUR_LSB +: 5];
      t.minute = w[`TSPC_MIN_LSB +: 6];
      t.second = w[`TSPC_SEC_LSB +: 6];
      return t;
   endfunction

   function automatic logic tod_ok(input tspc_tod_t t);
      tod_ok = (t.hour <= `TSPC_HOUR_MAX) && (t.minute <= `TSPC_MINSEC_MAX) &&
               (t.second <= `TSPC_MINSEC_MAX);
   endfunction

   function automatic logic [31:0] word_of(input tspc_tod_t t);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`TSPC_HOUR_LSB +: 5] = t.hour;
      w[`TSPC_MIN_LSB +: 6] = t.minute;
      w[`TSPC_SEC_LSB +: 6] = t.second;
      return w;
   endfunction

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_access = access_phase & pwrite;
   assign offset = 8'(paddr);
   assign wr_tod = tod_of(pwdata);
   assign wr_day = pwdata[`TSPC_DAY_LSB +: 5];

   always_comb begin
      addr_hit = 1'b1;
      addr_ro = 1'b0;
      if (paddr[ADDR_W-1:0] != ADDR_W'(offset)) begin
         addr_hit = 1'b0;
      end
      case (offset)
         `TSPC_OFS_TIMER1: addr_ro = 1'b0;
         `TSPC_OFS_TIMER2: addr_ro = 1'b0;
         `TSPC_OFS_ACT_DAY: addr_ro = 1'b0;
         `TSPC_OFS_ACT_TIME: addr_ro = 1'b0;
         `TSPC_OFS_WEEKDAYS: addr_ro = 1'b0;
         `TSPC_OFS_CTRL: addr_ro = 1'b0;
         `TSPC_OFS_STATUS: addr_ro = 1'b1;
         `TSPC_OFS_NOW: addr_ro = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Out-of-range settings are refused whole, never clipped
   always_comb begin
      case (offset)
         `TSPC_OFS_TIMER1: data_ok = tod_ok(wr_tod);
         `TSPC_OFS_TIMER2: data_ok = tod_ok(wr_tod);
         `TSPC_OFS_ACT_TIME: data_ok = tod_ok(wr_tod);
         `TSPC_OFS_ACT_DAY: data_ok = (wr_day >= `TSPC_DAY_MIN) &&
                                      (wr_day <= `TSPC_DAY_MAX);
         default: data_ok = 1'b1;
      endcase
   end

   assign wr_take = wr_access & addr_hit & ~addr_ro & data_ok;

   // ==========================================================
   // Write strobes, one load term per register
   logic wr_timer1;
   logic wr_timer2;
   logic wr_act_day;
   logic wr_act_time;
   logic wr_weekdays;
   logic wr_ctrl;
   assign wr_timer1 = wr_take & (offset == `TSPC_OFS_TIMER1);
   assign wr_timer2 = wr_take & (offset == `TSPC_OFS_TIMER2);
   assign wr_act_day = wr_take & (offset == `TSPC_OFS_ACT_DAY);
   assign wr_act_time = wr_take & (offset == `TSPC_OFS_ACT_TIME);
   assign wr_weekdays = wr_take & (offset == `TSPC_OFS_WEEKDAYS);
   assign wr_ctrl = wr_take & (offset == `TSPC_OFS_CTRL);

   // Zero wait states; error only during the access phase
   assign pready = 1'b1;
   assign pslverr = access_phase & (~addr_hit | (pwrite & (addr_ro | ~data_ok)));

   // ==========================================================
   // Daily timer setpoints
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer1.hour <= `TSPC_T1_HOUR_RST;
         timer1.minute <= `TSPC_MIN_RST;
         timer1.second <= `TSPC_SEC_RST;
      end else if (wr_timer1) begin
         timer1 <= wr_tod;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer2.hour <= `TSPC_T2_HOUR_RST;
         timer2.minute <= `TSPC_MIN_RST;
         timer2.second <= `TSPC_SEC_RST;
      end else if (wr_timer2) begin
         timer2 <= wr_tod;
      end
   end

   // ==========================================================
   // Active day, hour, minute, second setpoints
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_day <= `TSPC_ACT_DAY_RST;
      end else if (wr_act_day) begin
         act_day <= wr_day;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_tod.hour <= `TSPC_ACT_HOUR_RST;
         act_tod.minute <= `TSPC_MIN_RST;
         act_tod.second <= `TSPC_SEC_RST;
      end else if (wr_act_time) begin
         act_tod <= wr_tod;
      end
   end

   // ==========================================================
   // Weekday enables and control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         weekday_en <= `TSPC_WEEKDAYS_RST;
      end else if (wr_weekdays) begin
         weekday_en <= pwdata[`TSPC_WEEKDAYS_LSB +: 7];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en <= `TSPC_CTRL_EN_RST;
      end else if (wr_ctrl) begin
         ctrl_en <= pwdata[`TSPC_EN_BIT];
      end
   end

   // ==========================================================
   // Time snapshot taken on each tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         now_seen <= '0;
      end else if (sec_tick) begin
         now_seen <= now_time;
      end
   end

   // ==========================================================
   // Setpoint evaluation
   logic t1_reached;
   logic t2_reached;
   logic wday_hit;
   logic day_hit;
   logic hour_hit;
   logic min_hit;
   logic sec_hit;
   tspc_cmd_t next_cmd;

   tspc_cmp u_cmp_t1 (
      .now_tod(now_time.tod),
      .set_tod(timer1),
      .reached(t1_reached)
   );

   tspc_cmp u_cmp_t2 (
      .now_tod(now_time.tod),
      .set_tod(timer2),
      .reached(t2_reached)
   );

   // Weekday codes above Sunday never match
   always_comb begin
      wday_hit = 1'b0;
      if (now_time.weekday <= `TSPC_WDAY_MAX) begin
         wday_hit = weekday_en[now_time.weekday];
      end
   end

   // Plain equality, so each match spans its whole unit of time
   assign day_hit = (now_time.day == act_day);
   assign hour_hit = (now_time.tod.hour == act_tod.hour);
   assign min_hit = (now_time.tod.minute == act_tod.minute);
   assign sec_hit = (now_time.tod.second == act_tod.second);

   always_comb begin
      next_cmd = '0;
      if (ctrl_en) begin
         next_cmd[`TSPC_CMD_T1] = t1_reached;
         next_cmd[`TSPC_CMD_T2] = t2_reached;
         next_cmd[`TSPC_CMD_WDAY] = wday_hit;
         next_cmd[`TSPC_CMD_DAY] = day_hit;
         next_cmd[`TSPC_CMD_HOUR] = hour_hit;
         next_cmd[`TSPC_CMD_MIN] = min_hit;
         next_cmd[`TSPC_CMD_SEC] = sec_hit;
      end
   end

   // Outputs move only on a tick so they stay glitch free
   // between seconds; setting changes show at the next tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= '0;
      end else if (sec_tick) begin
         cmd <= next_cmd;
      end
   end

   assign cmd_out = cmd;

   // ==========================================================
   // Read data, captured in the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (offset)
         `TSPC_OFS_TIMER1: next_prdata = word_of(timer1);
         `TSPC_OFS_TIMER2: next_prdata = word_of(timer2);
         `TSPC_OFS_ACT_DAY: next_prdata[`TSPC_DAY_LSB +: 5] = act_day;
         `TSPC_OFS_ACT_TIME: next_prdata = word_of(act_tod);
         `TSPC_OFS_WEEKDAYS: next_prdata[`TSPC_WEEKDAYS_LSB +: 7] = weekday_en;
         `TSPC_OFS_CTRL: next_prdata[`TSPC_EN_BIT] = ctrl_en;
         `TSPC_OFS_STATUS: next_prdata[`TSPC_STATUS_LSB +: 7] = cmd;
         `TSPC_OFS_NOW: begin
            next_prdata = word_of(now_seen.tod);
            next_prdata[`TSPC_DAY_LSB +: 5] = now_seen.day;
            next_prdata[`TSPC_WDAY_LSB +: 3] = now_seen.weekday;
         end
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= addr_hit ? next_prdata : 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

//--- pkg/tspc_defs.svh
`ifndef TSPC_DEFS_SVH
`define TSPC_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define TSPC_OFS_TIMER1 8'h00
`define TSPC_OFS_TIMER2 8'h04
`define TSPC_OFS_ACT_DAY 8'h08
`define TSPC_OFS_ACT_TIME 8'h0C
`define TSPC_OFS_WEEKDAYS 8'h10
`define TSPC_OFS_CTRL 8'h14
`define TSPC_OFS_STATUS 8'h18
`define TSPC_OFS_NOW 8'h1C

// ==========================================================
// Field positions
`define TSPC_SEC_LSB 0
`define TSPC_MIN_LSB 8
`define TSPC_HOUR_LSB 16
`define TSPC_DAY_LSB 24
`define TSPC_WDAY_LSB 29
`define TSPC_EN_BIT 0
`define TSPC_WEEKDAYS_LSB 0
`define TSPC_STATUS_LSB 0

// ==========================================================
// Reset values
`define TSPC_T1_HOUR_RST 5'h08
`define TSPC_T2_HOUR_RST 5'h11
`define TSPC_ACT_HOUR_RST 5'h0C
`define TSPC_ACT_DAY_RST 5'h01
`define TSPC_MIN_RST 6'h00
`define TSPC_SEC_RST 6'h00
`define TSPC_WEEKDAYS_RST 7'h1F
`define TSPC_CTRL_EN_RST 1'h1

// ==========================================================
// Legal ranges
`define TSPC_HOUR_MAX 5'h17
`define TSPC_MINSEC_MAX 6'h3B
`define TSPC_DAY_MIN 5'h01
`define TSPC_DAY_MAX 5'h1F
`define TSPC_WDAY_MAX 3'h6

// ==========================================================
// Command output indexes
`define TSPC_CMD_T1 0
`define TSPC_CMD_T2 1
`define TSPC_CMD_WDAY 2
`define TSPC_CMD_DAY 3
`define TSPC_CMD_HOUR 4
`define TSPC_CMD_MIN 5
`define TSPC_CMD_SEC 6

`endif

//--- pkg/tspc_pkg.sv
`default_nettype none

package tspc_pkg;

   // ==========================================================
   // Time carriers
   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
   } tspc_tod_t;

   typedef struct packed {
      logic [4:0] day;
      logic [2:0] weekday;
      tspc_tod_t tod;
   } tspc_cal_t;

   typedef logic [6:0] tspc_cmd_t;

endpackage

`default_nettype wire

//--- test/tspc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Consumer: timer one opens, timer two closes a daily window
module tspc_engine_model (
   input wire tspc_pkg::tspc_cmd_t cmd,
   output logic window_on
);
   import tspc_pkg::*;
   assign window_on = cmd[0] & ~cmd[1];
endmodule
`default_nettype wire

//--- test/tspc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tspc_defs.svh"
// ====================
// Port-level checker
module tspc_top_props #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire tspc_pkg::tspc_cal_t now_time,
   input wire logic sec_tick,
   input wire tspc_pkg::tspc_cmd_t cmd_out
);
   import tspc_pkg::*;
   tspc_tod_t t1_set;
   tspc_tod_t t2_set;
   tspc_tod_t act_set;
   logic [4:0] day_set;
   logic [6:0] wday_set;
   logic en;
   logic [6:0] exp_cmd;
   logic acc_wr;
   assign acc_wr = psel && penable && pwrite && pready && !pslverr;
   // ====================
   // Shadow of accepted settings; refused writes leave it alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t1_set <= '{`TSPC_T1_HOUR_RST, `TSPC_MIN_RST, `TSPC_SEC_RST};
         t2_set <= '{`TSPC_T2_HOUR_RST, `TSPC_MIN_RST, `TSPC_SEC_RST};
         day_set <= `TSPC_ACT_DAY_RST;
         wday_set <= `TSPC_WEEKDAYS_RST;
         act_set <= '{`TSPC_ACT_HOUR_RST, `TSPC_MIN_RST, `TSPC_SEC_RST};
         en <= `TSPC_CTRL_EN_RST;
      end else if (acc_wr) begin
         if (paddr == `TSPC_OFS_TIMER1) t1_set <= '{pwdata[20:16], pwdata[13:8], pwdata[5:0]};
         if (paddr == `TSPC_OFS_TIMER2) t2_set <= '{pwdata[20:16], pwdata[13:8], pwdata[5:0]};
         if (paddr == `TSPC_OFS_ACT_DAY) day_set <= pwdata[28:24];
         if (paddr == `TSPC_OFS_WEEKDAYS) wday_set <= pwdata[6:0];
         if (paddr == `TSPC_OFS_ACT_TIME) act_set <= '{pwdata[20:16], pwdata[13:8], pwdata[5:0]};
         if (paddr == `TSPC_OFS_CTRL) en <= pwdata[0];
      end
   end
   always_comb begin
      exp_cmd = '0;
      if (en) begin
         exp_cmd[0] = now_time.tod >= t1_set;
         exp_cmd[1] = now_time.tod >= t2_set;
         exp_cmd[2] = (now_time.weekday != 3'h7) && wday_set[now_time.weekday];
         exp_cmd[3] = now_time.day == day_set;
         exp_cmd[4] = now_time.tod.hour == act_set.hour;
         exp_cmd[5] = now_time.tod.minute == act_set.minute;
         exp_cmd[6] = now_time.tod.second == act_set.second;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_tick;
      sec_tick;
   endsequence
   chk_cmd_hold: assert property (!sec_tick |=> $stable(cmd_out))
      else $error("command outputs moved without a tick");
   chk_reset_quiet: assert property (disable iff (1'b0) !presetn |-> cmd_out == '0)
      else $error("command outputs high in reset");
   chk_timer_start: assert property (s_tick |=> cmd_out[0] == $past(exp_cmd[0]))
      else $error("timer one wrong after tick");
   chk_hour_match: assert property (s_tick |=> cmd_out[4] == $past(exp_cmd[4]))
      else $error("hour match wrong after tick");
   chk_minute_match: assert property (s_tick |=> cmd_out[5] == $past(exp_cmd[5]))
      else $error("minute match wrong after tick");
   chk_second_match: assert property (s_tick |=> cmd_out[6] == $past(exp_cmd[6]))
      else $error("second match wrong after tick");
   chk_timer_two: assert property (s_tick |=> cmd_out[1] == $past(exp_cmd[1]))
      else $error("timer two wrong after tick");
   chk_weekday_match: assert property (s_tick |=> cmd_out[2] == $past(exp_cmd[2]))
      else $error("weekday match wrong after tick");
   chk_day_match: assert property (s_tick |=> cmd_out[3] == $past(exp_cmd[3]))
      else $error("day match wrong after tick");
   chk_bad_weekday: assert property (s_tick ##0 now_time.weekday == 3'h7 |=> !cmd_out[2])
      else $error("weekday match on invalid code");
   chk_unmapped_err: assert property (psel && penable && paddr > `TSPC_OFS_NOW |-> pslverr)
      else $error("unmapped access not refused");
   chk_ro_refused: assert property (psel && penable && pwrite && paddr == `TSPC_OFS_STATUS |-> pslverr)
      else $error("status write not refused");
endmodule
bind tspc_top tspc_top_props #(.ADDR_W(ADDR_W)) u_tspc_top_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .now_time(now_time),
   .sec_tick(sec_tick), .cmd_out(cmd_out));
`default_nettype wire

//--- test/tspc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tspc_defs.svh"
module tspc_top_tb;
   import tspc_pkg::*;
   typedef struct packed {tspc_cal_t cal; tspc_cmd_t exp;} tspc_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sec_tick, win, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   tspc_cal_t now_time;
   tspc_cmd_t cmd_out;
   tspc_row_t rows[7];
   int miscompares, cmp_count, cycles;
   logic [31:0] rst_exp[6] = '{32'h0008_0000, 32'h0011_0000, 32'h0100_0000, 32'h000C_0000,
      32'h0000_001F, 32'h0000_0001};
   logic [39:0] bad[3] = '{{8'h00, 32'h0018_0000}, {8'h0C, 32'h0000_3C00}, {8'h08, 32'h0}};
   logic [39:0] good[4] = '{{8'h00, 32'h0017_3B3B}, {8'h0C, 32'h0005_0709},
      {8'h08, 32'h1F00_0000}, {8'h10, 32'h0000_0040}};
   tspc_top u_tspc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .now_time(now_time), .sec_tick(sec_tick), .cmd_out(cmd_out));
   tspc_engine_model u_tspc_engine_model (.cmd(cmd_out), .window_on(win));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ====================
   // Hang guard: the whole run needs about a hundred cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   function automatic tspc_cal_t cal(input logic [4:0] d, input logic [2:0] w,
      input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
      return {d, w, h, m, s};
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask
   // Idle cycle after each transfer keeps one assignment per time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tick(input tspc_cal_t c, input tspc_cmd_t e);
      now_time <= c;
      sec_tick <= 1'b1;
      @(posedge pclk);
      sec_tick <= 1'b0;
      @(posedge pclk);
      check("cmd_out", 32'(e), 32'(cmd_out));
      check("window", 32'(e[0] & ~e[1]), 32'(win));
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, sec_tick, presetn} = '0;
      now_time = '0;
      rows[0] = {cal(1, 0, 0, 0, 0), 7'h6C};
      rows[1] = {cal(1, 0, 7, 59, 59), 7'h0C};
      rows[2] = {cal(2, 5, 8, 0, 0), 7'h61};
      rows[3] = {cal(31, 6, 12, 0, 59), 7'h31};
      rows[4] = {cal(3, 4, 17, 0, 0), 7'h67};
      rows[5] = {cal(3, 7, 23, 59, 59), 7'h03};
      rows[6] = {cal(3, 4, 16, 59, 59), 7'h05};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("cmd_idle", 32'h0, 32'(cmd_out));
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check("reset_val", rst_exp[i], rd);
      end
      for (int i = 0; i < 7; i++) tick(rows[i].cal, rows[i].exp);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped_err", 32'h1, 32'(err));
      check("unmapped_rd", 32'h0, rd);
      apb(1'b1, `TSPC_OFS_STATUS, 32'h7F);
      check("status_wr_err", 32'h1, 32'(err));
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, bad[i][39:32], bad[i][31:0]);
         check("range_err", 32'h1, 32'(err));
         apb(1'b0, bad[i][39:32], 32'h0);
         check("kept", rst_exp[bad[i][39:34]], rd);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, good[i][39:32], good[i][31:0]);
         check("edge_ok", 32'h0, 32'(err));
      end
      check("no_early", 32'h05, 32'(cmd_out));
      apb(1'b0, `TSPC_OFS_STATUS, 32'h0);
      check("status_rd", 32'h0000_0005, rd);
      apb(1'b0, `TSPC_OFS_NOW, 32'h0);
      check("now_rd", 32'h8310_3B3B, rd);
      tick(cal(31, 6, 23, 59, 58), 7'h0E);
      tick(cal(31, 6, 23, 59, 59), 7'h0F);
      tick(cal(31, 6, 5, 7, 9), 7'h7C);
      tick(cal(31, 0, 5, 7, 9), 7'h78);
      apb(1'b1, `TSPC_OFS_CTRL, 32'h0);
      tick(cal(31, 6, 5, 7, 9), 7'h00);
      presetn <= 1'b0;
      @(posedge pclk);
      check("cmd_in_reset", 32'h0, 32'(cmd_out));
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `TSPC_OFS_TIMER1, 32'h0);
      check("timer1_rst", rst_exp[0], rd);
      results();
   end
endmodule
`default_nettype wire
